// ### rtl/i2c_host_end.sv
// Purpose: host end, runs start, byte, stop and clear orders on the link
// Assumes: software orders one step at a time over the register port
// Notes: scl made from clk_sys by a phase counter
`timescale 1ns/1ps
`default_nettype none

module i2c_host_end #(
  parameter logic [15:0] PHASE_RESET = i2c_access_pkg::PHASE_STD
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_q,
  i2c_link_if.host link
);
  import i2c_access_pkg::*;

  if (PHASE_RESET < PHASE_FAST_MIN) begin : g_bad_phase
    $error("PHASE_RESET makes scl faster than fast mode");
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_STA_REL = 4'h1, S_STA_HI = 4'h2, S_STA_LOW = 4'h3,
    S_BIT_LO = 4'h4, S_BIT_SET = 4'h5, S_BIT_HI = 4'h6, S_STO_LO = 4'h7,
    S_STO_HI = 4'h8, S_STO_REL = 4'h9, S_CLR_LO = 4'ha, S_CLR_HI = 4'hb,
    S_CLR_WAIT = 4'hc, S_BIT_END = 4'hd
  } hstate_type;

  hstate_type state_q;
  logic [15:0] phase_len_q;
  logic [15:0] timer_q;
  logic tick;
  logic sda_meta_q;
  logic sda_s_q;
  logic scl_q;
  logic sda_oe_q;
  logic rstpin_q;
  logic [8:0] sh_q;
  logic [8:0] rx_q;
  logic [3:0] bitcnt_q;
  logic nack_q;
  logic refused_q;
  logic addr_next_q;
  logic [2:0] code;
  logic idle;
  logic cmd_wr;
  logic refuse;
  logic go;

  assign idle = (state_q == S_IDLE);
  assign tick = (timer_q == 16'h0000);
  assign code = reg_wdata[CMD_LSB +: 3];
  assign cmd_wr = reg_wr && reg_addr == REG_CMD;
  // byte and stop orders need scl low, i.e. an open frame
  always_comb begin
    refuse = 1'b0;
    if (!idle) begin
      refuse = 1'b1;
    end else if (code == CMD_WRITE && addr_next_q && reg_wdata[TX_LSB + 1 +: 7] >= PROBE_LIMIT) begin
      refuse = 1'b1;
    end else if ((code == CMD_WRITE || code == CMD_READ_ACK || code == CMD_READ_NACK || code == CMD_STOP) && scl_q) begin
      refuse = 1'b1;
    end else if (code == 3'h0 || code == 3'h7) begin
      refuse = 1'b1;
    end
  end
  assign go = cmd_wr && !refuse;

  // ----------------------------------------
  // phase timer and input sync
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer_q <= 16'h0000;
      sda_meta_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else if (ce) begin
      sda_meta_q <= link.sda;
      sda_s_q <= sda_meta_q;
      if (idle || tick) begin
        timer_q <= phase_len_q - 16'h0001;
      end else begin
        timer_q <= timer_q - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // link sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
      rstpin_q <= 1'b1;
      sh_q <= 9'h1ff;
      rx_q <= 9'h000;
      bitcnt_q <= 4'h0;
      nack_q <= 1'b0;
      addr_next_q <= 1'b0;
    end else if (ce) begin
      if (go) begin
        unique case (code)
          CMD_START: begin
            sda_oe_q <= 1'b0;
            addr_next_q <= 1'b1;
            state_q <= S_STA_REL;
          end
          CMD_STOP: begin
            sda_oe_q <= 1'b1;
            addr_next_q <= 1'b0;
            state_q <= S_STO_LO;
          end
          CMD_WRITE: begin
            sh_q <= {reg_wdata[TX_LSB +: 8], 1'b1};
            addr_next_q <= 1'b0;
            bitcnt_q <= 4'h0;
            state_q <= S_BIT_LO;
          end
          CMD_READ_ACK, CMD_READ_NACK: begin
            sh_q <= {8'hff, code == CMD_READ_NACK};
            addr_next_q <= 1'b0;
            bitcnt_q <= 4'h0;
            state_q <= S_BIT_LO;
          end
          CMD_CLEAR: begin
            sda_oe_q <= 1'b0;
            scl_q <= 1'b0;
            rstpin_q <= 1'b0;
            bitcnt_q <= 4'h0;
            state_q <= S_CLR_WAIT;
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end else if (tick) begin
        unique case (state_q)
          S_IDLE: state_q <= S_IDLE;
          S_STA_REL: begin scl_q <= 1'b1; state_q <= S_STA_HI; end
          S_STA_HI: begin sda_oe_q <= 1'b1; state_q <= S_STA_LOW; end
          S_STA_LOW: begin scl_q <= 1'b0; state_q <= S_IDLE; end
          S_BIT_LO: begin sda_oe_q <= ~sh_q[8]; state_q <= S_BIT_SET; end
          S_BIT_SET: begin scl_q <= 1'b1; state_q <= S_BIT_HI; end
          S_BIT_HI: begin
            rx_q <= {rx_q[7:0], sda_s_q};
            sh_q <= {sh_q[7:0], 1'b1};
            scl_q <= 1'b0;
            if (bitcnt_q == 4'h8) begin
              nack_q <= sda_s_q;
              // one more low phase, so a quick next order cannot shorten the scl period
              state_q <= S_BIT_END;
            end else begin
              bitcnt_q <= bitcnt_q + 4'h1;
              state_q <= S_BIT_LO;
            end
          end
          S_STO_LO: begin scl_q <= 1'b1; state_q <= S_STO_HI; end
          S_STO_HI: begin sda_oe_q <= 1'b0; state_q <= S_STO_REL; end
          S_STO_REL: state_q <= S_IDLE;
          S_BIT_END: state_q <= S_IDLE;
          // clear pulses keep the same three-phase period as data bits
          S_CLR_WAIT: state_q <= S_CLR_LO;
          S_CLR_LO: begin scl_q <= 1'b1; state_q <= S_CLR_HI; end
          S_CLR_HI: begin
            if (bitcnt_q == CLEAR_PULSES - 4'h1) begin
              rstpin_q <= 1'b1;
              state_q <= S_IDLE;
            end else begin
              scl_q <= 1'b0;
              bitcnt_q <= bitcnt_q + 4'h1;
              state_q <= S_CLR_WAIT;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_len_q <= PHASE_RESET;
      refused_q <= 1'b0;
      reg_rdata_q <= 16'h0000;
    end else if (ce) begin
      if (reg_wr && reg_addr == REG_PHASE) begin
        // clamped so scl never passes the fast-mode rate
        phase_len_q <= (reg_wdata < PHASE_FAST_MIN) ? PHASE_FAST_MIN : reg_wdata;
      end
      // a refusal in the same cycle as the clearing read wins
      if (cmd_wr && refuse) begin
        refused_q <= 1'b1;
      end else if (reg_rd && reg_addr == REG_STATUS) begin
        refused_q <= 1'b0;
      end
      reg_rdata_q <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          REG_STATUS: begin
            reg_rdata_q[ST_RX_LSB +: 8] <= rx_q[8:1];
            reg_rdata_q[ST_REFUSED] <= refused_q;
            reg_rdata_q[ST_NACK] <= nack_q;
            reg_rdata_q[ST_BUSY] <= !idle;
          end
          REG_PHASE: reg_rdata_q <= phase_len_q;
          default: reg_rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign link.scl = scl_q;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = sda_oe_q;
  assign link.active_low_device_reset_pin = rstpin_q;
endmodule : i2c_host_end

`default_nettype wire

// ### rtl/i2c_access_pkg.sv
// Purpose: shared constants for the register access link, host and target ends
// Assumes: clk_sys at 20 MHz, link clock made by the host end
// Notes: host register port is 2-bit address, 16-bit data
//
// How it works
// - scl at most 100 kHz standard, 400 kHz fast
// - target answers bus address 0x32
// - pointer selects the register each byte uses
// - host writes pointer byte before relying on it
// - host reads via repeated start, no stop
// - pointer steps by one after every data byte, read or written
// - stop ends the transaction, bus released
// - pointer wraps from ff to 00
// - nine bare clock pulses do not recover
// - host holds device reset low while clearing
// - host probes only addresses below 0x78
// - registers 0x88 to 0x8b read back writes
// - host power-cycles device after scratch testing; the bench instead holds the reset pin low through a bus clear
// - host leaves configuration registers to the library

package i2c_access_pkg;
  // ----------------------------------------
  // clock and link rate
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned SCL_STD_HZ = 100000;
  localparam int unsigned SCL_FAST_HZ = 400000;
  // a bit takes three phases: low, data set, high
  localparam int unsigned BIT_PHASES = 3;
  localparam logic [15:0] PHASE_STD = 16'((CLK_HZ + BIT_PHASES * SCL_STD_HZ - 1) / (BIT_PHASES * SCL_STD_HZ));
  localparam logic [15:0] PHASE_FAST_MIN = 16'((CLK_HZ + BIT_PHASES * SCL_FAST_HZ - 1) / (BIT_PHASES * SCL_FAST_HZ));
  localparam logic [3:0] CLEAR_PULSES = 4'h9;

  // ----------------------------------------
  // target side
  // ----------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h32;
  localparam logic [6:0] PROBE_LIMIT = 7'h78;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_FIRST = 8'h88;
  localparam logic [7:0] SCRATCH_LAST = 8'h8b;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------
  // host register port
  // ----------------------------------------
  localparam logic [1:0] REG_CMD = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_PHASE = 2'h2;
  localparam int unsigned CMD_LSB = 0;
  localparam int unsigned TX_LSB = 8;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_NACK = 1;
  localparam int unsigned ST_REFUSED = 2;
  localparam int unsigned ST_RX_LSB = 8;
  localparam logic [2:0] CMD_START = 3'h1;
  localparam logic [2:0] CMD_STOP = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_READ_ACK = 3'h4;
  localparam logic [2:0] CMD_READ_NACK = 3'h5;
  localparam logic [2:0] CMD_CLEAR = 3'h6;
endpackage : i2c_access_pkg

// ### rtl/i2c_link_if.sv
// Purpose: two-wire link between host end and target end
// Assumes: open-drain sda, scl driven by the host only
// Notes: the wired-and level of sda is resolved here
`timescale 1ns/1ps
`default_nettype none

interface i2c_link_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic active_low_device_reset_pin;
  logic sda;

  assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

  modport host (
    output scl,
    output sda_host_o,
    output sda_host_oe,
    output active_low_device_reset_pin,
    input sda
  );

  modport device (
    input scl,
    input sda,
    input active_low_device_reset_pin,
    output sda_dev_o,
    output sda_dev_oe
  );
endinterface : i2c_link_if

`default_nettype wire

// ### rtl/i2c_bus_condition.sv
// Purpose: start and stop detection on the data line edges
// Assumes: sda only moves while scl is high for start or stop
// Notes: flops clocked by sda, each signal owned by one edge
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_condition (
  input wire logic rst,
  input wire logic ce,
  input wire logic scl,
  input wire logic sda,
  output logic start_tgl_q,
  output logic frame_open
);
  logic open_q;
  logic close_q;

  // start: falling sda with scl high; flips a toggle per start
  always_ff @(negedge sda or posedge rst) begin
    if (rst) begin
      start_tgl_q <= 1'b0;
      open_q <= 1'b0;
    end else if (ce && scl) begin
      start_tgl_q <= ~start_tgl_q;
      open_q <= ~close_q;
    end
  end

  // stop: rising sda with scl high closes the frame
  always_ff @(posedge sda or posedge rst) begin
    if (rst) begin
      close_q <= 1'b0;
    end else if (ce && scl) begin
      close_q <= open_q;
    end
  end

  assign frame_open = open_q ^ close_q;
endmodule : i2c_bus_condition

`default_nettype wire

// ### rtl/i2c_device_end.sv
// Purpose: target end, register access through an auto-stepping pointer
// Assumes: clocked by the link scl; host keeps sda still while scl high
// Notes: bytes sampled on rising scl, sda driven on falling scl
`timescale 1ns/1ps
`default_nettype none

module i2c_device_end #(
  parameter logic [6:0] BUS_ADDR = i2c_access_pkg::TARGET_ADDR
) (
  input wire logic rst,
  input wire logic ce,
  i2c_link_if.device link,
  output logic [7:0] pointer_q,
  output logic matched_q
);
  import i2c_access_pkg::*;

  // ----------------------------------------
  // checks and types
  // ----------------------------------------
  if (BUS_ADDR >= PROBE_LIMIT || BUS_ADDR < 7'h08) begin : g_bad_addr
    $error("BUS_ADDR lies in a reserved range");
  end

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_ADDR = 3'h1,
    PH_PTR = 3'h2,
    PH_WDATA = 3'h3,
    PH_RDATA = 3'h4
  } phase_type;

  function automatic logic in_scratch(input logic [7:0] p);
    in_scratch = (p >= SCRATCH_FIRST) && (p <= SCRATCH_LAST);
  endfunction : in_scratch

  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    next_ptr = p + 8'h01;
  endfunction : next_ptr

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic dev_rst;
  logic start_tgl;
  logic frame_open;
  logic start_seen_q;
  logic start_new;
  phase_type phase_q;
  logic [3:0] cnt_q;
  logic [6:0] shift_q;
  logic [7:0] byte_in;
  logic ack_q;
  logic drive_q;
  logic [7:0] tx_q;
  logic [7:0] rd_byte;
  logic scratch_we;
  logic [7:0] scratch_q [4];

  // the reset pin wins over everything, so a stuck bus is cleared
  // only by holding it low; bare clock pulses never resync the state
  assign dev_rst = rst || !link.active_low_device_reset_pin;

  i2c_bus_condition u_cond (
    .rst(dev_rst),
    .ce(ce),
    .scl(link.scl),
    .sda(link.sda),
    .start_tgl_q(start_tgl),
    .frame_open(frame_open)
  );

  assign start_new = (start_tgl != start_seen_q);
  assign byte_in = {shift_q, link.sda};

  // ----------------------------------------
  // receive side, rising scl
  // ----------------------------------------
  always_ff @(posedge link.scl or posedge dev_rst) begin
    if (dev_rst) begin
      start_seen_q <= 1'b0;
      phase_q <= PH_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 7'h00;
      ack_q <= 1'b0;
      pointer_q <= PTR_RESET;
      matched_q <= 1'b0;
    end else if (ce) begin
      start_seen_q <= start_tgl;
      if (start_new) begin
        // a new start aborts any burst and expects an address
        phase_q <= PH_ADDR;
        cnt_q <= 4'h1;
        shift_q <= {6'h00, link.sda};
        ack_q <= 1'b0;
      end else if (!frame_open) begin
        phase_q <= PH_IDLE;
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
      end else if (phase_q != PH_IDLE) begin
        if (cnt_q == 4'h8) begin
          cnt_q <= 4'h0;
          ack_q <= 1'b0;
          // host not-acknowledge ends a read burst
          if (phase_q == PH_RDATA && !ack_q && link.sda) begin
            phase_q <= PH_IDLE;
          end
        end else begin
          shift_q <= byte_in[6:0];
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'h7) begin
            unique case (phase_q)
              PH_ADDR: begin
                if (byte_in[7:1] == BUS_ADDR) begin
                  ack_q <= 1'b1;
                  matched_q <= 1'b1;
                  phase_q <= byte_in[0] ? PH_RDATA : PH_PTR;
                end else begin
                  matched_q <= 1'b0;
                  phase_q <= PH_IDLE;
                end
              end
              PH_PTR: begin
                pointer_q <= byte_in;
                ack_q <= 1'b1;
                phase_q <= PH_WDATA;
              end
              PH_WDATA: begin
                pointer_q <= next_ptr(pointer_q);
                ack_q <= 1'b1;
              end
              PH_RDATA: begin
                pointer_q <= next_ptr(pointer_q);
              end
              PH_IDLE: begin
                phase_q <= PH_IDLE;
              end
              default: begin
                phase_q <= PH_IDLE;
              end
            endcase
          end
        end
      end
    end
  end

  // ----------------------------------------
  // scratch registers
  // ----------------------------------------
  assign scratch_we = !start_new && frame_open && phase_q == PH_WDATA && cnt_q == 4'h7 && in_scratch(pointer_q);

  always_ff @(posedge link.scl or posedge dev_rst) begin
    if (dev_rst) begin
      for (int i = 0; i < 4; i++) begin
        scratch_q[i] <= SCRATCH_RESET;
      end
    end else if (ce && scratch_we) begin
      scratch_q[2'(pointer_q - SCRATCH_FIRST)] <= byte_in;
    end
  end

  // other registers are not held by this port and read as a constant
  always_comb begin
    if (in_scratch(pointer_q)) begin
      rd_byte = scratch_q[2'(pointer_q - SCRATCH_FIRST)];
    end else begin
      rd_byte = UNMAPPED_READ;
    end
  end

  // ----------------------------------------
  // transmit side, falling scl
  // ----------------------------------------
  always_ff @(negedge link.scl or posedge dev_rst) begin
    if (dev_rst) begin
      drive_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (ce) begin
      if (start_new || !frame_open) begin
        drive_q <= 1'b0;
      end else if (cnt_q == 4'h8) begin
        drive_q <= ack_q;
      end else if (phase_q == PH_RDATA && cnt_q == 4'h0) begin
        tx_q <= rd_byte;
        drive_q <= ~rd_byte[7];
      end else if (phase_q == PH_RDATA) begin
        drive_q <= ~tx_q[3'(4'h7 - cnt_q)];
      end else begin
        drive_q <= 1'b0;
      end
    end
  end

  // gating by the frame level lets a stop free sda at once
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = drive_q && frame_open;
endmodule : i2c_device_end

`default_nettype wire

// ### bench/i2c_link_assertions.sv
// Purpose: link-level checks between host end and target end
// Assumes: clk_sys samples the link far faster than scl moves
// Notes: takes the interface signals as plain inputs, no bind
`timescale 1ns/1ps
`default_nettype none

module i2c_link_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic active_low_device_reset_pin
);
  logic scl_q;
  logic [7:0] per_q;
  logic [3:0] pulse_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
    end else begin
      scl_q <= scl;
    end
  end

  // saturates so the first rise after reset never looks short
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      per_q <= 8'hff;
    end else if (scl && !scl_q) begin
      per_q <= 8'h00;
    end else if (per_q != 8'hff) begin
      per_q <= per_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulse_q <= 4'h0;
    end else if (active_low_device_reset_pin) begin
      pulse_q <= 4'h0;
    end else if (scl && !scl_q) begin
      pulse_q <= pulse_q + 4'h1;
    end
  end

  // ----------------------------------------
  // link conditions
  // ----------------------------------------
  sequence start_cond;
    scl && $fell(sda);
  endsequence

  sequence stop_cond;
    scl && $rose(sda);
  endsequence

  // 400 kHz at 20 MHz is 50 cycles rise to rise
  a_scl_rate: assert property ($rose(scl) |-> per_q >= 8'h31)
    else $error("scl period shorter than fast mode allows");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*2])
    else $error("scl high width too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*6])
    else $error("scl low width too short");
  a_start_hold: assert property (start_cond |-> scl [*2])
    else $error("scl fell too soon after start");
  a_start_setup: assert property (start_cond |-> $past(scl, 1) && $past(scl, 2))
    else $error("start setup time too short");
  a_stop_setup: assert property (stop_cond |-> $past(scl, 12))
    else $error("stop setup time too short");
  a_stop_quiet: assert property (stop_cond |=> !sda_dev_oe [*8])
    else $error("target drove sda after stop");
  a_dev_low_scl: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("target took sda while scl high");
  a_dev_reset_quiet: assert property (!active_low_device_reset_pin |-> !sda_dev_oe)
    else $error("target drove sda during reset");
  a_clear_pulses: assert property ($rose(active_low_device_reset_pin) |-> pulse_q == 4'h9)
    else $error("reset pin not held for nine pulses");
endmodule : i2c_link_assertions

`default_nettype wire

// ### bench/test_i2c_register_access_target.sv
// Purpose: host end and target end joined, driven through host registers
// Assumes: phase register set to its minimum to keep the run short
// Notes: expectations come from the pointer, scratch, address and refusal rules and the phase clamp
`timescale 1ns/1ps
`default_nettype none

module test_i2c_register_access_target;
  import i2c_access_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata_q;
  logic [7:0] pointer_q;
  logic matched_q;
  logic [15:0] st;
  logic [7:0] pat [4] = '{8'h3c, 8'ha5, 8'h0f, 8'hf0};
  logic [2:0] bad [3] = '{3'h0, 3'h7, CMD_WRITE};
  int err_count = 0;
  int comparisons = 0;

  always #25 clk_sys = ~clk_sys;

  i2c_link_if link ();
  i2c_host_end #(.PHASE_RESET(PHASE_STD)) i2c_host_end_i (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .link(link));
  i2c_device_end #(.BUS_ADDR(TARGET_ADDR)) i2c_device_end_i (.rst(rst), .ce(1'b1), .link(link),
    .pointer_q(pointer_q), .matched_q(matched_q));
  i2c_link_assertions i2c_link_assertions_i (.clk_sys(clk_sys), .rst(rst), .scl(link.scl), .sda(link.sda),
    .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe),
    .active_low_device_reset_pin(link.active_low_device_reset_pin));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask : rd

  // one order, then poll busy; a refused order never sets busy
  task automatic xfer(input logic [2:0] code, input logic [7:0] b, output logic [15:0] s);
    int n;
    wr(REG_CMD, {b, 5'h00, code});
    n = 0;
    s = 16'h0001;
    while (s[ST_BUSY] !== 1'b0 && n < 1000) begin
      rd(REG_STATUS, s);
      n++;
    end
    if (n >= 1000) begin
      err_count++;
      close_out();
    end
  endtask : xfer

  task automatic bw(input logic [7:0] b, input logic nack);
    xfer(CMD_WRITE, b, st);
    chk({15'h0000, st[ST_NACK]}, {15'h0000, nack});
  endtask : bw

  task automatic open_w(input logic [7:0] ptr);
    xfer(CMD_START, 8'h00, st);
    bw({TARGET_ADDR, 1'b0}, 1'b0);
    bw(ptr, 1'b0);
  endtask : open_w

  task automatic open_r(input logic [7:0] ptr);
    open_w(ptr);
    xfer(CMD_START, 8'h00, st);
    bw({TARGET_ADDR, 1'b1}, 1'b0);
  endtask : open_r

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    // raised by an update at time 0 so the async-reset flops see an edge
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    chk({14'h0000, link.scl, link.sda}, 16'h0003);
    wr(REG_PHASE, 16'h0040);
    rd(REG_PHASE, st);
    chk(st, 16'h0040);
    wr(REG_PHASE, 16'h0005);
    rd(REG_PHASE, st);
    chk(st, PHASE_FAST_MIN);
    rd(2'h3, st);
    chk(st, 16'h0000);
    // burst write into the scratch block, stop right after it
    open_w(SCRATCH_FIRST);
    chk({15'h0000, matched_q}, 16'h0001);
    chk({8'h00, pointer_q}, 16'h0088);
    for (int i = 0; i < 4; i++) begin
      bw(pat[i], 1'b0);
    end
    chk({8'h00, pointer_q}, 16'h008c);
    xfer(CMD_STOP, 8'h00, st);
    chk({14'h0000, link.sda_dev_oe, link.sda}, 16'h0001);
    // burst read back through a repeated start
    open_r(SCRATCH_FIRST);
    for (int i = 0; i < 4; i++) begin
      xfer((i == 3) ? CMD_READ_NACK : CMD_READ_ACK, 8'h00, st);
      chk({8'h00, st[15:8]}, {8'h00, pat[i]});
    end
    chk({8'h00, pointer_q}, 16'h008c);
    xfer(CMD_STOP, 8'h00, st);
    // pointer rolls over at the top of the space
    // read, not write, so no configuration register is touched
    open_r(8'hff);
    xfer(CMD_READ_NACK, 8'h00, st);
    chk({8'h00, st[15:8]}, {8'h00, UNMAPPED_READ});
    chk({8'h00, pointer_q}, 16'h0000);
    xfer(CMD_STOP, 8'h00, st);
    // another target's address is left alone
    xfer(CMD_START, 8'h00, st);
    bw({7'h33, 1'b0}, 1'b1);
    chk({15'h0000, matched_q}, 16'h0000);
    xfer(CMD_STOP, 8'h00, st);
    // reserved probe address, bad codes and a write outside a frame never reach the link
    xfer(CMD_START, 8'h00, st);
    xfer(CMD_WRITE, {PROBE_LIMIT, 1'b0}, st);
    chk({15'h0000, st[ST_REFUSED]}, 16'h0001);
    xfer(CMD_STOP, 8'h00, st);
    for (int i = 0; i < 3; i++) begin
      xfer(bad[i], 8'h00, st);
      chk({15'h0000, st[ST_REFUSED]}, 16'h0001);
    end
    rd(REG_STATUS, st);
    chk({15'h0000, st[ST_REFUSED]}, 16'h0000);
    // bus clear with the reset pin low puts the target back to its start
    open_w(8'h89);
    xfer(CMD_STOP, 8'h00, st);
    chk({8'h00, pointer_q}, 16'h0089);
    xfer(CMD_CLEAR, 8'h00, st);
    chk({7'h00, matched_q, pointer_q}, 16'h0000);
    chk({15'h0000, link.scl}, 16'h0001);
    open_r(SCRATCH_FIRST);
    xfer(CMD_READ_NACK, 8'h00, st);
    chk({8'h00, st[15:8]}, {8'h00, SCRATCH_RESET});
    xfer(CMD_STOP, 8'h00, st);
    close_out();
  end
endmodule : test_i2c_register_access_target

`default_nettype wire
